// ---- rtl/pllsyn_pkg.sv ----
package pllsyn_pkg;

  // ==========================================================
  // Programming word layout
  localparam int PROG_W = 16;
  localparam int RATIO_W = 14;
  localparam int GAIN_HI = 15;
  localparam int GAIN_LO = 14;
  localparam logic [15:0] PROG_RST = 16'hFFFF;

  // ==========================================================
  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_LOCK_CFG = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

  localparam int CTRL_DIR_BIT = 0;
  localparam int CTRL_MON_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_STROBE_BIT = 1;
  localparam int STAT_GAIN_LO = 2;
  localparam int STAT_RATIO_LO = 16;

  localparam int IRQ_W = 3;
  localparam int IRQ_LOCK_BIT = 0;
  localparam int IRQ_UNLOCK_BIT = 1;
  localparam int IRQ_LOAD_BIT = 2;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;

  // ==========================================================
  // Lock filter
  localparam logic [15:0] LOCK_THR_RST = 16'h0100;
  localparam logic [15:0] LOCK_DN_STEP = 16'h0003;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    GAIN_X1_0,
    GAIN_X1_5,
    GAIN_X2_5,
    GAIN_X4_0
  } pllsyn_gain_e;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pllsyn_apb_rsp_s;

endpackage

// ---- rtl/pllsyn_core.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - RF ratio is main times modulus plus swallow
// - All ratios from N(N-1) upward are reachable
// - Strobe pulse loads the 16-bit bus word
// - Strobe low: bus changes are ignored
// - Strobe high: RF divider counters reset, bus passes through
// - Falling strobe keeps last word, releases counters
// - Pump up and down off while strobe high
// - Bits 15:14 pick pump current multiplier
// - Direction swaps comparator inputs and monitors
// - RF lag sources when direction 1, sinks otherwise
// - Monitor outputs held low when disabled
// - Phase/frequency detector gives up/down pulses
// - Up AND down discharges the lock node
// - Lock output low while node above half the threshold
// - Loss of lock reported about three times faster
// - Undriven programming bits read as one
module pllsyn_core
  import pllsyn_pkg::*;
#(
  parameter int PRESC_LOG2 = 3,
  parameter int REF_W = 10,
  parameter int LOCK_W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output pllsyn_apb_rsp_s apb_rsp_o,
  input wire logic strobe_i,
  input wire logic [PROG_W-1:0] prog_bus_i,
  input wire logic rf_pulse_i,
  input wire logic ref_pulse_i,
  input wire logic [REF_W-1:0] ref_ratio_i,
  output logic pump_up_o,
  output logic pump_dn_o,
  output pllsyn_gain_e pump_gain_o,
  output logic divided_rf_monitor_o,
  output logic divided_ref_monitor_o,
  output logic lock_n_o,
  output logic irq_o
);

  localparam int MAIN_W = RATIO_W - PRESC_LOG2;
  localparam int PRES_W = PRESC_LOG2 + 1;
  localparam logic [PRES_W-1:0] PRES_TERM_LO = PRES_W'((1 << PRESC_LOG2) - 1);
  localparam logic [PRES_W-1:0] PRES_TERM_HI = PRES_W'(1 << PRESC_LOG2);
  localparam logic [LOCK_W-1:0] DN_STEP = LOCK_W'(LOCK_DN_STEP);

  // ==========================================================
  // Programming word
  logic [PROG_W-1:0] prog_q;
  logic strobe_q;

  // Transparent while strobe is high, frozen while it is low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_q <= PROG_RST;
    end else if (strobe_i) begin
      prog_q <= prog_bus_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_i;
    end
  end

  assign pump_gain_o = pllsyn_gain_e'(prog_q[GAIN_HI:GAIN_LO]);

  logic [PRESC_LOG2-1:0] swal_val;
  logic [MAIN_W-1:0] main_val;
  assign swal_val = prog_q[PRESC_LOG2-1:0];
  assign main_val = prog_q[RATIO_W-1:PRESC_LOG2];

  // ==========================================================
  // Dual-modulus RF divider
  logic [PRES_W-1:0] pres_q;
  logic [PRESC_LOG2-1:0] swal_q;
  logic [MAIN_W-1:0] main_q;
  logic rf_div_q;
  logic pres_end;

  // Modulus N+1 while the swallow count is nonzero, N after
  assign pres_end = rf_pulse_i &&
    (pres_q == ((swal_q != '0) ? PRES_TERM_HI : PRES_TERM_LO));

  // Main count below swallow count gives a wrong ratio, hence the N(N-1) floor
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pres_q <= '0;
      swal_q <= '0;
      main_q <= '0;
      rf_div_q <= 1'b0;
    end else if (strobe_i) begin
      pres_q <= '0;
      swal_q <= '0;
      main_q <= '0;
      rf_div_q <= 1'b0;
    end else if (main_q == '0) begin
      pres_q <= '0;
      swal_q <= swal_val;
      main_q <= main_val;
      rf_div_q <= 1'b0;
    end else begin
      rf_div_q <= 1'b0;
      if (rf_pulse_i) begin
        pres_q <= pres_end ? '0 : pres_q + 1'b1;
      end
      if (pres_end) begin
        if (swal_q != '0) begin
          swal_q <= swal_q - 1'b1;
        end
        if (main_q == MAIN_W'(1)) begin
          main_q <= main_val;
          swal_q <= swal_val;
          rf_div_q <= 1'b1;
        end else begin
          main_q <= main_q - 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Reference divider
  logic [REF_W-1:0] ref_cnt_q;
  logic ref_div_q;
  logic ref_wrap;

  assign ref_wrap = (ref_cnt_q + 1'b1 >= ref_ratio_i);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_cnt_q <= '0;
      ref_div_q <= 1'b0;
    end else begin
      ref_div_q <= ref_pulse_i && ref_wrap;
      if (ref_pulse_i) begin
        ref_cnt_q <= ref_wrap ? '0 : ref_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // Register state and control register bits
  logic [1:0] ctrl_q;
  logic [LOCK_W-1:0] thr_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic dir_q;
  logic mon_en_q;
  assign dir_q = ctrl_q[CTRL_DIR_BIT];
  assign mon_en_q = ctrl_q[CTRL_MON_BIT];

  // ==========================================================
  // Phase/frequency detector and charge pump gate
  logic up_src;
  logic dn_src;
  logic up_q;
  logic dn_q;
  logic coinc;

  // Direction 1: reference edge first (RF lag) drives the source side
  assign up_src = dir_q ? ref_div_q : rf_div_q;
  assign dn_src = dir_q ? rf_div_q : ref_div_q;
  assign coinc = up_q && dn_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_q <= 1'b0;
      dn_q <= 1'b0;
    end else begin
      up_q <= (up_q || up_src) && !coinc;
      dn_q <= (dn_q || dn_src) && !coinc;
    end
  end

  // Pump stays off for the whole strobe so loads do not kick the VCO
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pump_up_o <= 1'b0;
      pump_dn_o <= 1'b0;
    end else begin
      pump_up_o <= ((up_q || up_src) && !coinc) && !strobe_i;
      pump_dn_o <= ((dn_q || dn_src) && !coinc) && !strobe_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divided_rf_monitor_o <= 1'b0;
      divided_ref_monitor_o <= 1'b0;
    end else begin
      divided_rf_monitor_o <= mon_en_q && dn_src;
      divided_ref_monitor_o <= mon_en_q && up_src;
    end
  end

  // ==========================================================
  // Lock filter
  logic [LOCK_W-1:0] node_q;
  logic locked;
  logic locked_q;

  // Node charges by one per cycle up to the threshold and loses three
  // per coincidence cycle; lock is shown above half the threshold
  assign locked = node_q > (thr_q >> 1);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      node_q <= '0;
    end else if (coinc) begin
      node_q <= (node_q > DN_STEP) ? node_q - DN_STEP : '0;
    end else if (node_q < thr_q) begin
      node_q <= node_q + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked_q <= 1'b0;
      lock_n_o <= 1'b1;
    end else begin
      locked_q <= locked;
      lock_n_o <= !locked;
    end
  end

  // ==========================================================
  // APB slave
  logic setup;
  logic access;
  logic wr_en;
  logic rd_stat;
  logic hit;
  logic [31:0] rd_val;

  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && apb_rsp_o.pready;
  assign wr_en = access && pwrite_i;
  assign rd_stat = access && !pwrite_i && (paddr_i == ADDR_IRQ_STAT);

  always_comb begin
    hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr_i)
      ADDR_CTRL: rd_val[1:0] = ctrl_q;
      ADDR_STATUS: begin
        rd_val[STAT_LOCK_BIT] = locked_q;
        rd_val[STAT_STROBE_BIT] = strobe_q;
        rd_val[STAT_GAIN_LO +: 2] = prog_q[GAIN_HI:GAIN_LO];
        rd_val[STAT_RATIO_LO +: RATIO_W] = prog_q[RATIO_W-1:0];
      end
      ADDR_LOCK_CFG: rd_val[LOCK_W-1:0] = thr_q;
      ADDR_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK: rd_val[IRQ_W-1:0] = irq_mask_q;
      default: hit = 1'b0;
    endcase
  end

  // One wait-free access phase: ready is raised by the setup cycle
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      apb_rsp_o <= '0;
    end else if (setup) begin
      apb_rsp_o.pready <= 1'b1;
      apb_rsp_o.pslverr <= !hit;
      apb_rsp_o.prdata <= pwrite_i ? 32'h0000_0000 : rd_val;
    end else begin
      apb_rsp_o <= '0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= CTRL_RST;
      thr_q <= LOCK_W'(LOCK_THR_RST);
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr_en) begin
      case (paddr_i)
        ADDR_CTRL: ctrl_q <= pwdata_i[1:0];
        ADDR_LOCK_CFG: thr_q <= pwdata_i[LOCK_W-1:0];
        ADDR_IRQ_MASK: irq_mask_q <= pwdata_i[IRQ_W-1:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // ==========================================================
  // Interrupts
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_stat_d;

  assign irq_evt[IRQ_LOCK_BIT] = locked && !locked_q;
  assign irq_evt[IRQ_UNLOCK_BIT] = !locked && locked_q;
  assign irq_evt[IRQ_LOAD_BIT] = strobe_q && !strobe_i;
  // A new event in the clearing read's cycle survives the clear
  assign irq_stat_d = (rd_stat ? '0 : irq_stat_q) | irq_evt;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_o <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_strobe_end;
    strobe_i ##1 !strobe_i;
  endsequence

  strobe_pump_off_a: assert property (strobe_i |=> !pump_up_o && !pump_dn_o)
    else $error("pump active during strobe");
  strobe_cnt_reset_a: assert property (strobe_i |=> main_q == '0 && swal_q == '0)
    else $error("counters not held during strobe");
  bus_pass_a: assert property (strobe_i |=> prog_q == $past(prog_bus_i))
    else $error("word not passed through");
  bus_ignore_a: assert property (!strobe_i |=> prog_q == $past(prog_q))
    else $error("word changed with strobe low");
  load_release_a: assert property (s_strobe_end |=> main_q == $past(main_val))
    else $error("counters not released after strobe");
  mon_disable_a: assert property (!mon_en_q |=>
    !divided_rf_monitor_o && !divided_ref_monitor_o)
    else $error("monitor active while disabled");
  pfd_lag_up_a: assert property (dir_q && ref_div_q && !dn_q && !strobe_i |=> pump_up_o)
    else $error("no source pulse on RF lag");
  loss_step_a: assert property (coinc && node_q > DN_STEP |=>
    node_q == $past(node_q) - DN_STEP)
    else $error("lock node discharge wrong");
  lock_show_a: assert property (locked |=> !lock_n_o)
    else $error("lock not indicated");
  apb_ready_a: assert property (setup |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
    else $error("ready not one cycle after setup");

endmodule

// ---- test/pllsyn_ctl_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Controller side of the parallel programming bus
module pllsyn_ctl_model (
  input wire logic clk_i,
  output logic strobe_o,
  output logic [15:0] bus_o
);
  initial begin
    strobe_o = 1'b0;
    bus_o = 16'hFFFF;
  end

  // Word changes while the strobe is high; only the last one should stick
  task automatic load(input logic [15:0] first_w, input logic [15:0] last_w, input int hold);
    @(posedge clk_i);
    strobe_o <= 1'b1;
    bus_o <= first_w;
    @(posedge clk_i);
    bus_o <= last_w;
    // One more high edge so the final word is sampled before the fall
    repeat (hold + 1) @(posedge clk_i);
    // Kept short so the pump is off as briefly as possible
    strobe_o <= 1'b0;
    @(posedge clk_i);
    // Bus no longer carries the word once the strobe is low
    bus_o <= ~last_w;
  endtask
endmodule

// ---- test/pllsyn_core_test.sv ----
`timescale 1ns/1ps
module pllsyn_core_test;
  import pllsyn_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic rf_pulse = 1'b0;
  logic ref_pulse = 1'b1;
  logic [9:0] ref_ratio = 10'h00A;
  pllsyn_apb_rsp_s rsp;
  pllsyn_gain_e gain;
  logic strobe, up, dn, mon_rf, mon_ref, lock_n, irq, er;
  logic [15:0] prog_bus;
  logic [15:0] w;
  logic [31:0] rd;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int p;

  always #12.5 mclk_i = ~mclk_i;

  pllsyn_ctl_model u_ctl (.clk_i(mclk_i), .strobe_o(strobe), .bus_o(prog_bus));

  pllsyn_core dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .apb_rsp_o(rsp), .strobe_i(strobe),
    .prog_bus_i(prog_bus), .rf_pulse_i(rf_pulse), .ref_pulse_i(ref_pulse),
    .ref_ratio_i(ref_ratio), .pump_up_o(up), .pump_dn_o(dn), .pump_gain_o(gain),
    .divided_rf_monitor_o(mon_rf), .divided_ref_monitor_o(mon_ref), .lock_n_o(lock_n),
    .irq_o(irq));

  // ==========================================================
  // Reporting
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("MISMATCH timeout expected end seen hang");
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ==========================================================
  // Bus access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk_i);
    penable <= 1'b1;
    // Ends when ready is seen; there is no local limit, so only the bench timeout ends it if ready never rises
    do begin
      @(posedge mclk_i);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Cycles between two divided pulses; the first wait skips a partial period
  task automatic period();
    int n;
    n = 0;
    // Let a pulse of the previous setting drain before looking
    repeat (2) @(negedge mclk_i);
    while (mon_rf !== 1'b1 && n < 600) begin
      @(negedge mclk_i);
      n++;
    end
    p = 0;
    do begin
      @(negedge mclk_i);
      p++;
    end while (mon_rf !== 1'b1 && p < 600);
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(negedge mclk_i);
    chk("lock_n", 32'h1, {31'h0, lock_n});
    chk("gain", 32'h3, {30'h0, gain});
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", {30'h0, CTRL_RST}, rd);
    apb(1'b0, ADDR_LOCK_CFG, 32'h0);
    chk("lock_cfg", {16'h0, LOCK_THR_RST}, rd);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk("mask", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("test reset done");
    repeat (300) @(negedge mclk_i);
    chk("locked", 32'h0, {31'h0, lock_n});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status lock", 32'h1, {31'h0, rd[STAT_LOCK_BIT]});
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("lock event", 32'h1, {31'h0, rd[IRQ_LOCK_BIT]});
    $display("test lock done");
    for (int g = 0; g < 4; g++) begin
      w = {2'(g), 14'(256 + g)};
      u_ctl.load(~w, w, g);
      @(negedge mclk_i);
      chk("gain", 32'(g), {30'h0, gain});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("ratio", {18'h0, w[13:0]}, {18'h0, rd[29:16]});
      chk("status gain", 32'(g), {30'h0, rd[3:2]});
      repeat (3) @(negedge mclk_i);
      chk("gain held", 32'(g), {30'h0, gain});
    end
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(negedge mclk_i);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("load event", 32'h1, {31'h0, rd[IRQ_LOAD_BIT]});
    @(negedge mclk_i);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    $display("test load done");
    repeat (30) @(negedge mclk_i);
    chk("up dir1", 32'h1, {31'h0, up});
    chk("dn dir1", 32'h0, {31'h0, dn});
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (30) @(negedge mclk_i);
    chk("up dir0", 32'h0, {31'h0, up});
    chk("dn dir0", 32'h1, {31'h0, dn});
    fork
      u_ctl.load(w, w, 6);
      begin
        repeat (4) @(negedge mclk_i);
        chk("up strobe", 32'h0, {31'h0, up});
        chk("dn strobe", 32'h0, {31'h0, dn});
      end
    join
    $display("test pump done");
    @(posedge mclk_i);
    rf_pulse <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 56 : (i == 1) ? 59 : 63;
      w = {2'b00, 14'(p)};
      apb(1'b1, ADDR_CTRL, 32'h3);
      u_ctl.load(w, w, 0);
      period();
      chk("rf period", {18'h0, w[13:0]}, 32'(p));
    end
    apb(1'b1, ADDR_CTRL, 32'h2);
    period();
    chk("swapped period", 32'd10, 32'(p));
    apb(1'b1, ADDR_CTRL, 32'h0);
    @(posedge mclk_i);
    p = 0;
    repeat (120) begin
      @(negedge mclk_i);
      if (mon_rf === 1'b1 || mon_ref === 1'b1) p++;
    end
    chk("monitor off", 32'h0, 32'(p));
    $display("test divider done");
    close_out();
  end
endmodule
